// ==== test/aser_remote_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module aser_remote_node (
   input wire logic clk, // Module clock
   input wire logic go, // Start a frame, one cycle
   input wire logic [31:0] bits, // Line levels, first bit in bit 0
   input wire logic [5:0] nbits, // Bit periods to send
   input wire logic [15:0] baud, // Clocks per bit
   output logic line, // Serial line toward the receiver
   output logic busy // Frame in progress
);
   logic [31:0] sh_q = 32'hFFFFFFFF;
   logic [5:0] left_q = 6'h00;
   logic [15:0] cnt_q = 16'h0001;
   // Idle line rests at mark level, as a pulled-up serial line does
   assign busy = (left_q != 6'h00);
   assign line = busy ? sh_q[0] : 1'b1;
   // Shift one level per bit period, LSB first
   always_ff @(posedge clk) begin
      if (go) begin
         sh_q <= bits;
         left_q <= nbits;
         cnt_q <= baud;
      end else if (busy) begin
         if (cnt_q == 16'h0001) begin
            sh_q <= {1'b1, sh_q[31:1]};
            left_q <= left_q - 6'h01;
            cnt_q <= baud;
         end else begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end
endmodule : aser_remote_node
`default_nettype wire

// ==== test/tb_aser_rx_err.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_aser_rx_err;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic irq, tx_pin, tx_oe, line, nd_busy;
   logic go = 1'b0;
   logic [31:0] bits = 32'h0;
   logic [5:0] nbits = 6'h00;
   int miscompares = 0;
   int n_compared = 0;
   // Small bit period keeps frames short
   localparam logic [15:0] BAUD = 16'h0008;
   always #12.5 clk = ~clk;
   aser_rx_err i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq(irq), .rx_pin(line), .tx_pin(tx_pin), .tx_oe(tx_oe));
   aser_remote_node i_node (.clk(clk), .go(go), .bits(bits), .nbits(nbits), .baud(BAUD), .line(line),
      .busy(nd_busy));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a, input logic [15:0] exp);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : reg_rd
   // Frame: start, data, two tail levels (parity or stop); periods past the tail stay low, giving a break
   task automatic send(input logic [7:0] d, input logic [1:0] tail, input logic [5:0] n);
      @(posedge clk) begin
         go <= 1'b1;
         bits <= {22'h3FFFFF, tail, d, 1'b0} & ~(((32'h1 << n) - 32'h1) & 32'hFFFFF800);
         nbits <= n;
      end
      @(posedge clk) go <= 1'b0;
      // The node loads on this edge; look at busy only once that update has settled
      #1;
      for (int i = 0; i < 400 && nd_busy; i++) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask : send
   task automatic t_reset;
      reg_rd(aser_pkg::ADDR_CTRL, {8'h00, aser_pkg::CTRL_RST});
      reg_rd(aser_pkg::ADDR_BAUD, aser_pkg::BAUD_RST);
      reg_rd(aser_pkg::ADDR_MASK, {8'h00, aser_pkg::MASK_RST});
      reg_rd(3'h7, 16'h0000);
      reg_wr(aser_pkg::ADDR_BAUD, BAUD);
      $display("test reset done");
   endtask : t_reset
   task automatic t_good;
      send(8'h5A, 2'b11, 6'd10);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0050);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0040);
      reg_rd(aser_pkg::ADDR_RXD, 16'h005A);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0000);
      $display("test good char done");
   endtask : t_good
   task automatic t_parity;
      reg_wr(aser_pkg::ADDR_CTRL, 16'h0005);
      send(8'h01, 2'b10, 6'd11);
      send(8'h03, 2'b10, 6'd11);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0053);
      reg_rd(aser_pkg::ADDR_RXD, 16'h0003);
      send(8'h01, 2'b11, 6'd11);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0050);
      reg_rd(aser_pkg::ADDR_RXD, 16'h0001);
      $display("test parity done");
   endtask : t_parity
   task automatic t_overrun;
      reg_wr(aser_pkg::ADDR_CTRL, 16'h0001);
      reg_wr(aser_pkg::ADDR_MASK, 16'h0002);
      send(8'h11, 2'b11, 6'd10);
      chk({15'h0, irq}, 16'h0000);
      send(8'h22, 2'b11, 6'd10);
      chk({15'h0, irq}, 16'h0001);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0052);
      reg_rd(aser_pkg::ADDR_RXD, 16'h0022);
      repeat (2) @(posedge clk);
      chk({15'h0, irq}, 16'h0000);
      $display("test overrun done");
   endtask : t_overrun
   task automatic t_break;
      reg_wr(aser_pkg::ADDR_MASK, 16'h0004);
      send(8'h00, 2'b00, 6'd23);
      chk({15'h0, irq}, 16'h0001);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0024);
      // Low stop then one good-looking stop level: only the first counts
      reg_wr(aser_pkg::ADDR_MASK, 16'h0000);
      send(8'h77, 2'b10, 6'd11);
      chk({15'h0, irq}, 16'h0000);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0004);
      reg_wr(aser_pkg::ADDR_CTRL, 16'h0011);
      send(8'h00, 2'b00, 6'd23);
      reg_rd(aser_pkg::ADDR_STAT, 16'h0004);
      $display("test break done");
   endtask : t_break
   task automatic t_tx;
      logic [10:0] f;
      for (int odd = 0; odd < 2; odd++) begin
         reg_wr(aser_pkg::ADDR_CTRL, 16'h0005 | 16'(odd << 1));
         f = {1'b1, 1'(odd), 8'hA5, 1'b0};
         reg_wr(aser_pkg::ADDR_TXD, 16'h00A5);
         repeat (3) @(posedge clk);
         #1;
         for (int i = 0; i < 11; i++) begin
            chk({15'h0, tx_pin}, {15'h0, f[i]});
            repeat (8) @(posedge clk);
            #1;
         end
         chk({15'h0, tx_oe}, 16'h0001);
      end
      $display("test transmit done");
   endtask : t_tx
   task automatic t_loop;
      reg_wr(aser_pkg::ADDR_CTRL, 16'h0021);
      reg_wr(aser_pkg::ADDR_TXD, 16'h003C);
      repeat (60) @(posedge clk);
      chk({15'h0, tx_pin}, 16'h0001);
      repeat (60) @(posedge clk);
      reg_rd(aser_pkg::ADDR_RXD, 16'h003C);
      reg_wr(aser_pkg::ADDR_CTRL, 16'h0040);
      repeat (2) @(posedge clk);
      chk({15'h0, tx_oe}, 16'h0001);
      $display("test loopback done");
   endtask : t_loop
   task automatic t_sync;
      reg_wr(aser_pkg::ADDR_CTRL, 16'h0091);
      reg_wr(aser_pkg::ADDR_MASK, 16'h0008);
      // A low stop arms the measurement; the next start bit is timed against the divider
      send(8'h00, 2'b00, 6'd23);
      reg_wr(aser_pkg::ADDR_BAUD, 16'h0009);
      send(8'h55, 2'b11, 6'd10);
      chk({15'h0, irq}, 16'h0000);
      reg_rd(aser_pkg::ADDR_BAUD, BAUD);
      // Divider far from the line rate: out of tolerance, no adjustment
      send(8'h00, 2'b00, 6'd23);
      reg_wr(aser_pkg::ADDR_BAUD, 16'h000C);
      send(8'h55, 2'b11, 6'd10);
      chk({15'h0, irq}, 16'h0001);
      reg_rd(aser_pkg::ADDR_BAUD, 16'h000C);
      $display("test sync field done");
   endtask : t_sync
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_good();
      t_parity();
      t_overrun();
      t_break();
      t_tx();
      t_loop();
      t_sync();
      tally_and_finish();
   end
   // Watchdog: the sequence needs a few thousand cycles
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
endmodule : tb_aser_rx_err
`default_nettype wire

// ==== verilog/aser_pkg.sv ====
`default_nettype none
package aser_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_BAUD = 3'h1;
   localparam logic [2:0] ADDR_TXD = 3'h2;
   localparam logic [2:0] ADDR_RXD = 3'h3;
   localparam logic [2:0] ADDR_STAT = 3'h4;
   localparam logic [2:0] ADDR_MASK = 3'h5;
   // global_control_one fields
   localparam int CTL_TX_EN = 0;
   localparam int CTL_PAR_ODD = 1;
   localparam int CTL_PAR_EN = 2;
   localparam int CTL_ADDR_MODE = 3;
   localparam int CTL_LIN_MODE = 4;
   localparam int CTL_DLB = 5;
   localparam int CTL_ALB = 6;
   localparam int CTL_SYNC_EN = 7;
   // receive_status_register fields
   localparam int ST_PE = 0;
   localparam int ST_OE = 1;
   localparam int ST_FE = 2;
   localparam int ST_SYNC_FIELD_MISMATCH_FLAG = 3;
   localparam int ST_RXRDY = 4;
   localparam int ST_BRK = 5;
   localparam int ST_FULL = 6;
   localparam int ST_TXBUSY = 7;
   localparam logic [7:0] ST_STICKY = 8'h3F;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam int CLK_HZ = 40000000;
   localparam int BAUD_HZ = 115200;
   localparam logic [15:0] BAUD_RST = 16'(CLK_HZ / BAUD_HZ);
   // Break length in bit periods; sync tolerance as a divider shift
   localparam logic [3:0] BRK_BITS = 4'hA;
   localparam int SYNC_TOL_SHIFT = 3;
   typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_BREAK, RX_WAITHI} aser_rx_state_t;
endpackage : aser_pkg
`default_nettype wire

// ==== verilog/aser_rx_err.sv ====
// Behaviour
// - Receive line low ten bit periods after missing stop sets break flag, interrupt; the interrupt is raised only when mask bit 5 is set.
// - Break flag sits at bit 5 of the receive status register.
// - Break detection works only while not in LIN mode.
// - Framing flag set when stop-bit sample is not high.
// - Only the first stop bit is checked.
// - Framing error interrupts only when its enable bit is set.
// - Format mismatches are flagged, interrupting only when software enabled it.
// - LIN sync field measured, baud adjusted; out of tolerance sets mismatch flag.
// - Overrun flag set when a new character overwrites an unread one.
// - Overrun interrupts only when its enable bit is one.
// - Older unread data is replaced by new data.
// - Transmitter inserts a hardware parity bit when parity is enabled.
// - Receiver checks parity in hardware and may interrupt on error.
// - Digital loopback at module boundary; analog loopback via pad, driver on.
// - Parity error when ones count mismatches; address bit counted in address mode.
// - With parity disabled the parity flag is inactive and reads zero.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module aser_rx_err (
   input wire logic clk, // 40 MHz module clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [2:0] addr, // Register index
   input wire logic [15:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [15:0] rdata, // Read data, cycle after rd
   output logic irq, // Level interrupt
   input wire logic rx_pin, // Serial receive pad input
   output logic tx_pin, // Serial transmit pad output
   output logic tx_oe // Transmit driver enable
);
   // Parity bit over payload; used by both transmitter and receiver
   function automatic logic aser_par(input logic [8:0] v, input logic odd);
      aser_par = (^v) ^ odd;
   endfunction : aser_par

   logic [7:0] ctrl_q, mask_q, stat_q, stat_d, st_set, rxd_q, txd_q;
   logic [15:0] baud_q, tmr_q, ttmr_q, meas_q;
   logic [9:0] rxsh_q, rxw;
   logic [11:0] txsh_q, tx_load;
   logic [3:0] idx_q, txn_q, brk_q;
   logic [2:0] rx_sync_q;
   logic rx_s_q, rx_prev_q, rx_full_q, sync_arm_q, sync_on_q, tx_busy_q, tx_q, irq_q, tx_oe_q;
   logic [15:0] rdata_q;
   logic tx_pad_q;
   aser_pkg::aser_rx_state_t st_q;

   // Decode
   wire wr_ctrl = wr && addr == aser_pkg::ADDR_CTRL;
   wire wr_baud = wr && addr == aser_pkg::ADDR_BAUD;
   wire wr_mask = wr && addr == aser_pkg::ADDR_MASK;
   wire rd_rxd = rd && addr == aser_pkg::ADDR_RXD;
   wire rd_stat = rd && addr == aser_pkg::ADDR_STAT;
   wire par_en = ctrl_q[aser_pkg::CTL_PAR_EN];
   wire par_odd = ctrl_q[aser_pkg::CTL_PAR_ODD];
   wire amode = ctrl_q[aser_pkg::CTL_ADDR_MODE];
   wire lin = ctrl_q[aser_pkg::CTL_LIN_MODE];
   wire dlb = ctrl_q[aser_pkg::CTL_DLB];
   wire alb = ctrl_q[aser_pkg::CTL_ALB];
   wire [3:0] nbits = 4'h8 + {3'h0, amode} + {3'h0, par_en};

   // Receive source: digital loopback closes inside; analog uses the pad with driver forced on
   wire rx_b = dlb ? tx_q : rx_s_q;
   wire fall = rx_prev_q && !rx_b;
   wire rise = !rx_prev_q && rx_b;
   wire tick = tmr_q == 16'h0000;
   wire ttick = ttmr_q == 16'h0000;

   // Align the shifted word so bit 0 is the first data bit
   assign rxw = (nbits == 4'hA) ? rxsh_q : (nbits == 4'h9) ? {1'b0, rxsh_q[9:1]} : {2'b00, rxsh_q[9:2]};
   wire rx_abit = amode && rxw[8];
   wire rx_pbit = amode ? rxw[9] : rxw[8];
   wire par_bad = par_en && aser_par({rx_abit, rxw[7:0]}, par_odd) != rx_pbit;
   wire stop_tk = st_q == aser_pkg::RX_STOP && tick;
   wire char_done = stop_tk && rx_b;
   wire fe_ev = stop_tk && !rx_b;
   wire brk_ev = st_q == aser_pkg::RX_BREAK && tick && !rx_b && brk_q == aser_pkg::BRK_BITS - 4'h1;

   // Sync field check: start-bit length against divider, tolerance one eighth
   wire [15:0] tol = baud_q >> aser_pkg::SYNC_TOL_SHIFT;
   wire sync_end = sync_on_q && rise;
   wire sync_bad = (meas_q > baud_q + tol) || (meas_q + tol < baud_q);

   // Transmit frame: start, data, optional address bit, optional parity, stop
   wire tx_go = wr && addr == aser_pkg::ADDR_TXD && !tx_busy_q && ctrl_q[aser_pkg::CTL_TX_EN];
   wire tx_p = aser_par({amode && wdata[8], wdata[7:0]}, par_odd);
   assign tx_load = amode ? (par_en ? {1'b1, tx_p, wdata[8], wdata[7:0], 1'b0} : {2'b11, wdata[8], wdata[7:0], 1'b0})
                          : (par_en ? {2'b11, tx_p, wdata[7:0], 1'b0} : {3'b111, wdata[7:0], 1'b0});

   // Event sources; parity events dropped while parity is off
   assign st_set = {2'b00, brk_ev, char_done, sync_end && sync_bad, fe_ev, char_done && rx_full_q,
                    char_done && par_bad};
   assign stat_d = ((stat_q & ~(rd_stat ? aser_pkg::ST_STICKY : 8'h00)) | st_set) & aser_pkg::ST_STICKY;

   // Pad input filter: three flops, change taken once second and third agree
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_sync_q <= 3'h7;
         rx_s_q <= 1'b1;
      end else begin
         rx_sync_q <= {rx_sync_q[1:0], rx_pin};
         if (rx_sync_q[1] == rx_sync_q[2]) begin
            rx_s_q <= rx_sync_q[2];
         end
      end
   end

   // Software registers; sync success overwrites the divider
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_q <= aser_pkg::CTRL_RST;
         mask_q <= aser_pkg::MASK_RST;
         baud_q <= aser_pkg::BAUD_RST;
      end else begin
         if (wr_ctrl) ctrl_q <= wdata[7:0];
         if (wr_mask) mask_q <= wdata[7:0];
         if (wr_baud) baud_q <= wdata;
         else if (sync_end && !sync_bad) baud_q <= meas_q;
      end
   end

   // Status, interrupt and read data; the event wins over the clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stat_q <= 8'h00;
         irq_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         stat_q <= stat_d;
         irq_q <= |(stat_q & mask_q);
         rdata_q <= 16'h0000;
         if (rd) begin
            case (addr)
               aser_pkg::ADDR_CTRL: rdata_q <= {8'h00, ctrl_q};
               aser_pkg::ADDR_BAUD: rdata_q <= baud_q;
               aser_pkg::ADDR_TXD: rdata_q <= {8'h00, txd_q};
               aser_pkg::ADDR_RXD: rdata_q <= {8'h00, rxd_q};
               aser_pkg::ADDR_STAT: rdata_q <= {8'h00, tx_busy_q, rx_full_q, stat_q[5:1], stat_q[0] && par_en};
               aser_pkg::ADDR_MASK: rdata_q <= {8'h00, mask_q};
               default: rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   // Receive FSM with mid-bit sampling
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= aser_pkg::RX_IDLE;
         tmr_q <= 16'h0000;
         idx_q <= 4'h0;
         brk_q <= 4'h0;
         rxsh_q <= 10'h000;
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_b;
         tmr_q <= tick ? baud_q - 16'h0001 : tmr_q - 16'h0001;
         case (st_q)
            aser_pkg::RX_IDLE: begin
               if (fall) begin
                  st_q <= aser_pkg::RX_START;
                  tmr_q <= baud_q >> 1;
               end
            end
            aser_pkg::RX_START: begin
               if (tick) begin
                  st_q <= rx_b ? aser_pkg::RX_IDLE : aser_pkg::RX_BITS; // Glitch shorter than half a bit is dropped
                  idx_q <= 4'h0;
               end
            end
            aser_pkg::RX_BITS: begin
               if (tick) begin
                  rxsh_q <= {rx_b, rxsh_q[9:1]};
                  idx_q <= idx_q + 4'h1;
                  if (idx_q == nbits - 4'h1) st_q <= aser_pkg::RX_STOP;
               end
            end
            aser_pkg::RX_STOP: begin
               if (tick) begin
                  brk_q <= 4'h0;
                  // Further stop bits are never sampled; a high stop restarts idle hunting at once
                  st_q <= rx_b ? aser_pkg::RX_IDLE : (lin ? aser_pkg::RX_WAITHI : aser_pkg::RX_BREAK);
               end
            end
            aser_pkg::RX_BREAK: begin
               if (tick) begin
                  brk_q <= brk_q + 4'h1;
                  if (rx_b) st_q <= aser_pkg::RX_IDLE;
                  else if (brk_ev) st_q <= aser_pkg::RX_WAITHI;
               end
            end
            aser_pkg::RX_WAITHI: begin
               if (rx_b) st_q <= aser_pkg::RX_IDLE;
            end
            default: st_q <= aser_pkg::RX_IDLE;
         endcase
      end
   end

   // Receive buffer and sync measurement; a new character always replaces the old one
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxd_q <= 8'h00;
         rx_full_q <= 1'b0;
         sync_arm_q <= 1'b0;
         sync_on_q <= 1'b0;
         meas_q <= 16'h0000;
      end else begin
         if (char_done) rxd_q <= rxw[7:0];
         rx_full_q <= char_done || (rx_full_q && !rd_rxd);
         if (st_q == aser_pkg::RX_WAITHI && lin && ctrl_q[aser_pkg::CTL_SYNC_EN]) sync_arm_q <= 1'b1;
         if (sync_arm_q && fall) begin
            sync_arm_q <= 1'b0;
            sync_on_q <= 1'b1;
            meas_q <= 16'h0001;
         end else if (sync_end) begin
            sync_on_q <= 1'b0;
         end else if (sync_on_q) begin
            meas_q <= meas_q + 16'h0001;
         end
      end
   end

   // Transmitter and pad drive
   always_ff @(posedge clk) begin
      if (!rstn) begin
         txsh_q <= 12'hFFF;
         txn_q <= 4'h0;
         ttmr_q <= 16'h0000;
         tx_busy_q <= 1'b0;
         txd_q <= 8'h00;
         tx_q <= 1'b1;
         tx_oe_q <= 1'b0;
      end else begin
         tx_oe_q <= ctrl_q[aser_pkg::CTL_TX_EN] || alb;
         if (tx_go) begin
            txd_q <= wdata[7:0];
            txsh_q <= tx_load;
            txn_q <= nbits + 4'h2;
            ttmr_q <= baud_q - 16'h0001;
            tx_busy_q <= 1'b1;
            tx_q <= 1'b0;
         end else if (tx_busy_q) begin
            ttmr_q <= ttick ? baud_q - 16'h0001 : ttmr_q - 16'h0001;
            if (ttick) begin
               txsh_q <= {1'b1, txsh_q[11:1]};
               tx_q <= txsh_q[1];
               txn_q <= txn_q - 4'h1;
               if (txn_q == 4'h1) tx_busy_q <= 1'b0;
            end
         end
      end
   end

   // Next pad level, worked out ahead so the pad gets a flop of its own while loopback still sees tx_q
   wire tx_d = tx_go ? 1'b0 : (tx_busy_q && ttick) ? txsh_q[1] : tx_q;
   wire dlb_d = wr_ctrl ? wdata[aser_pkg::CTL_DLB] : dlb;

   // Digital loopback keeps the pad idle so the far node sees nothing
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_pad_q <= 1'b1;
      end else begin
         tx_pad_q <= tx_d || dlb_d;
      end
   end

   assign tx_pin = tx_pad_q;
   assign tx_oe = tx_oe_q;
   assign irq = irq_q;
   assign rdata = rdata_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_fe_flag: assert property (fe_ev |=> stat_q[aser_pkg::ST_FE])
      else $error("framing event not flagged");
   a_brk_source: assert property ($rose(stat_q[aser_pkg::ST_BRK]) |-> $past(st_q) == aser_pkg::RX_BREAK && $past(brk_q) == 4'h9)
      else $error("break flag without ten low periods");
   a_brk_lin: assert property (lin && st_q != aser_pkg::RX_BREAK |=> st_q != aser_pkg::RX_BREAK)
      else $error("break hunting in lin mode");
   a_overrun_set: assert property (char_done && rx_full_q |=> stat_q[aser_pkg::ST_OE] && rx_full_q)
      else $error("overrun not flagged");
   a_data_replace: assert property (char_done |=> rxd_q == $past(rxw[7:0]))
      else $error("new data not stored");
   a_irq_gate: assert property (!(|(stat_q & mask_q)) ##1 !(|(stat_q & mask_q)) |=> !irq_q)
      else $error("interrupt without enabled flag");
   a_oe_irq: assert property (stat_q[aser_pkg::ST_OE] && mask_q[aser_pkg::ST_OE] |=> irq_q)
      else $error("enabled overrun did not interrupt");
   a_pe_off: assert property (rd_stat && !par_en |=> !rdata_q[aser_pkg::ST_PE])
      else $error("parity flag read while parity off");
   a_flag_hold: assert property (stat_q[aser_pkg::ST_FE] && !rd_stat |=> stat_q[aser_pkg::ST_FE])
      else $error("error flag lost");
   a_tx_start: assert property (tx_go && !dlb |=> !tx_pin ##1 tx_busy_q)
      else $error("start bit missing");
   a_sync_adjust: assert property (sync_end && !sync_bad && !wr_baud |=> baud_q == $past(meas_q))
      else $error("divider not adjusted to sync field");
   c_break: cover property (brk_ev);
   c_overrun: cover property (char_done && rx_full_q);
   c_sync_bad: cover property (sync_end && sync_bad);
   c_sync_good: cover property (sync_end && !sync_bad);
   c_parity: cover property (char_done && par_bad);
endmodule : aser_rx_err
`default_nettype wire
